// >>> verilog/dbc_params.svh
// Constants of the DRAM bank controller: offsets, counts and phase points.
// Assumes a 200 MHz clock and a refresh timer stepped at the 25 MHz bus rate.
`ifndef DBC_PARAMS_SVH
`define DBC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Clock and refresh timing
// ----------------------------------------------------------------------------
`define DBC_CLOCK_MHZ      200
`define DBC_TICK_MHZ       25
`define DBC_TICK_DIV       (`DBC_CLOCK_MHZ / `DBC_TICK_MHZ)
`define DBC_REF_PERIOD_NS  9600
`define DBC_REF_LOAD       8'h0f
`define DBC_REF_TOP        8'hff
`define DBC_TRAS_MAX_NS    10000
`define DBC_TRAS_MAX_CYC   ((`DBC_TRAS_MAX_NS * `DBC_CLOCK_MHZ + 999) / 1000)

// ----------------------------------------------------------------------------
// Address decoding
// ----------------------------------------------------------------------------
`define DBC_SPACE_BIT      22
`define DBC_BANK_HI        21
`define DBC_BANK_LO        20

// ----------------------------------------------------------------------------
// Sequencer phase points (values of the four-bit counter)
// ----------------------------------------------------------------------------
`define DBC_T_RAS          4'h1
`define DBC_T_COL          4'h2
`define DBC_T_CAS          4'h3
`define DBC_T_ACK          4'h4
`define DBC_T_END          4'h5
`define DBC_T_BLK_END      4'ha
`define DBC_T_PRE          4'h2
`define DBC_T_REF_RAS      4'h1
`define DBC_T_REF_END      4'h5
`define DBC_T_PG_CAS       4'h1
`define DBC_T_PG_END       4'h2

`endif

// >>> verilog/dbc_pkg.sv
// Types shared by the DRAM bank controller.
// Assumes the constants of dbc_params.svh are included where numbers are needed.
package dbc_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [8:0] {
    DBC_RESET    = 9'h001,
    DBC_IDLE     = 9'h002,
    DBC_REFRESH  = 9'h004,
    DBC_RD_SGL   = 9'h008,
    DBC_RD_BLK   = 9'h010,
    DBC_WR_SGL   = 9'h020,
    DBC_WR_PAGE  = 9'h040,
    DBC_IDLE_RAS = 9'h080,
    DBC_PRECHG   = 9'h100
  } dbc_state_e;

  typedef logic [3:0] dbc_cnt_t;

endpackage

// >>> verilog/dbc_ctrl.sv
// DRAM bank controller: decode, bank select, strobes, byte writes, refresh.
// Assumes a latched address, active-low bus strobes synchronous to clock,
// and external row/column multiplexers and latching data transceivers.
//
// Function
// R1 - DRAM access only when address bit 22 low
// R2 - Bits 21:20 choose one of four banks
// R3 - Read low alone reads, write low alone writes
// R4 - Each bank has own row and column strobe
// R5 - DRAM occupies lowest 4MB, bits 21..0
// R6 - Writes enable only the marked byte lanes
// R7 - Lane enables combine byte enables with write
// R8 - Refresh request raised every 9.6 microseconds
// R9 - Row strobe never held low past 10us
// R10 - Four-bit counter sequences all DRAM timing
// R11 - Nine major states, chosen by transfer type
// R12 - Reset clears and aligns the state machine
// R13 - Reset state performs exactly one refresh
// R14 - Idle arbitrates refresh against bus access
// R15 - Access starts on strobe with bit 22 low
// R16 - Refresh need seen from timer pulse
// R17 - Block read, single read, single write, page write
// R18 - After writes, idle with row strobe held
// R19 - Near write completes as page access
// R20 - Leaving row-held idle precharges the row first
// R21 - Data transceivers keep DRAM and processor apart
// R22 - Outside mux forms row and column address
// R23 - Timer loads 0x0f, pulses at 0xff
// R24 - Address stable one cycle before strobes
// R25 - Refresh arriving mid-access stays pending
`timescale 1ns/1ps

`include "dbc_params.svh"

module dbc_ctrl
  import dbc_pkg::*;
#(
  parameter int TICK_DIV = `DBC_TICK_DIV
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [22:0] addr,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [3:0]  be_n,
  input  wire logic        block_req,
  input  wire logic        wr_near,
  output logic      [3:0]  ras_n_reg,
  output logic      [3:0]  cas_n_reg,
  output logic      [3:0]  wb_n_reg,
  output logic             dram_wr_n_reg,
  output logic             addr_col_reg,
  output logic             latch_en_reg,
  output logic             xcv_to_cpu_reg,
  output logic             ack_reg,
  output logic             rd_word_reg,
  output logic      [1:0]  blk_word_reg,
  output logic             reset_cycle_active_reg,
  output logic             ref_ack_reg
);

  localparam int PW = $clog2(TICK_DIV);
  function automatic logic [3:0] bank_dec(input logic [1:0] b);
    return 4'h1 << b;
  endfunction

  // --------------------------------------------------------------------------
  // Request decoding
  // --------------------------------------------------------------------------
  dbc_state_e st_reg, st_next;
  dbc_cnt_t   cnt_reg, cnt_next;
  logic [1:0] bank_reg, bank_next;
  logic [3:0] ras_next, cas_next;
  logic       col_next, wr_next, le_next, dir_next, ack_next, rdw_next;
  logic       rip_next, refack_next;
  logic       done_reg, ref_pend_reg, ref_pulse_reg;
  logic [PW-1:0] pre_reg;
  logic [7:0] tmr_reg;

  // R1 - space check
  wire in_space = ~addr[`DBC_SPACE_BIT];
  // R3 - R15 - strobe decode
  wire req_rd = ~rd_n & wr_n & in_space & ~done_reg;
  wire req_wr = ~wr_n & rd_n & in_space & ~done_reg;
  // R2 - R5 - bank field
  wire [1:0] addr_bank = addr[`DBC_BANK_HI:`DBC_BANK_LO];
  wire near_hit = req_wr & wr_near & (addr_bank == bank_reg);
  wire is_ref = (st_reg == DBC_RESET) | (st_reg == DBC_REFRESH);
  wire tick = (pre_reg == PW'(TICK_DIV - 1));
  wire ref_start = refack_next;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg + 4'h1;
    bank_next = bank_reg;
    ras_next = 4'hf;
    cas_next = 4'hf;
    col_next = 1'b0;
    wr_next = 1'b1;
    le_next = 1'b0;
    dir_next = 1'b0;
    ack_next = 1'b0;
    rdw_next = 1'b0;
    rip_next = 1'b0;
    refack_next = 1'b0;
    case (st_reg)
      // R13 - one refresh during reset
      DBC_RESET, DBC_REFRESH: begin
        rip_next = (st_reg == DBC_RESET);
        cas_next = 4'h0;
        ras_next = (cnt_reg >= `DBC_T_REF_RAS) ? 4'h0 : 4'hf;
        if (cnt_reg == `DBC_T_REF_END) begin
          ras_next = 4'hf;
          cas_next = 4'hf;
          rip_next = 1'b0;
          refack_next = 1'b1;
          st_next = DBC_IDLE;
          cnt_next = 4'h0;
        end
      end
      // R14 - refresh wins arbitration
      DBC_IDLE: begin
        cnt_next = 4'h0;
        bank_next = addr_bank;
        if (ref_pend_reg) begin
          st_next = DBC_REFRESH;
        end else if (req_rd) begin
          st_next = block_req ? DBC_RD_BLK : DBC_RD_SGL;
        end else if (req_wr) begin
          st_next = DBC_WR_SGL;
        end
      end
      // R17 - single read, single write, block refill
      DBC_RD_SGL, DBC_WR_SGL, DBC_RD_BLK: begin
        // R24 - row address holds a cycle before RAS
        ras_next = (cnt_reg >= `DBC_T_RAS) ? ~bank_dec(bank_reg) : 4'hf;
        // R22 - R24 - column select a cycle before CAS
        if (cnt_reg >= `DBC_T_COL) begin
          col_next = 1'b1;
          wr_next = (st_reg != DBC_WR_SGL);
        end
        // R21 - transceivers face the processor only on reads
        dir_next = (st_reg != DBC_WR_SGL);
        if (st_reg == DBC_RD_BLK) begin
          cas_next = (cnt_reg >= `DBC_T_CAS && cnt_reg < `DBC_T_BLK_END && cnt_reg[0]) ? ~bank_dec(bank_reg) : 4'hf;
          le_next = (cnt_reg >= `DBC_T_ACK) && !cnt_reg[0];
          rdw_next = le_next;
          if (cnt_reg == `DBC_T_BLK_END) begin
            ack_next = 1'b1;
            st_next = DBC_PRECHG;
            cnt_next = 4'h0;
          end
        end else begin
          cas_next = (cnt_reg >= `DBC_T_CAS && cnt_reg < `DBC_T_END) ? ~bank_dec(bank_reg) : 4'hf;
          ack_next = (cnt_reg == `DBC_T_ACK);
          le_next = ack_next && (st_reg == DBC_RD_SGL);
          rdw_next = le_next;
          // R18 - writes leave the row open
          if (cnt_reg == `DBC_T_END) begin
            st_next = (st_reg == DBC_WR_SGL) ? DBC_IDLE_RAS : DBC_PRECHG;
            cnt_next = 4'h0;
          end
        end
      end
      // R18 - row held, columns released
      DBC_IDLE_RAS: begin
        ras_next = ~bank_dec(bank_reg);
        col_next = 1'b1;
        cnt_next = 4'h0;
        // R9 - pending refresh closes the row in time
        if (ref_pend_reg || req_rd || (req_wr && !near_hit)) begin
          st_next = DBC_PRECHG;
        end else if (near_hit) begin
          st_next = DBC_WR_PAGE;
        end
      end
      // R19 - near write without reopening the row
      DBC_WR_PAGE: begin
        ras_next = ~bank_dec(bank_reg);
        col_next = 1'b1;
        wr_next = (cnt_reg == `DBC_T_PG_END);
        cas_next = (cnt_reg >= `DBC_T_PG_CAS && cnt_reg < `DBC_T_PG_END) ? ~bank_dec(bank_reg) : 4'hf;
        if (cnt_reg == `DBC_T_PG_END) begin
          ack_next = 1'b1;
          st_next = DBC_IDLE_RAS;
          cnt_next = 4'h0;
        end
      end
      // R20 - precharge before any other transaction
      DBC_PRECHG: begin
        if (cnt_reg == `DBC_T_PRE) begin
          st_next = DBC_IDLE;
          cnt_next = 4'h0;
        end
      end
      default: begin
        st_next = DBC_RESET;
        cnt_next = 4'h0;
      end
    endcase
  end

  // R12 - reset aligns the sequencer
  // R10 - R11 - four-bit counter and nine-state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= DBC_RESET;
      cnt_reg <= 4'h0;
      bank_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bank_reg <= bank_next;
    end
  end

  // --------------------------------------------------------------------------
  // Registered strobes and responses
  // --------------------------------------------------------------------------
  // R4 - per-bank strobes
  // R6 - R7 - lane enables follow byte enables only while writing
  always_ff @(posedge clock) begin
    if (rst) begin
      ras_n_reg <= 4'hf;
      cas_n_reg <= 4'hf;
      wb_n_reg <= 4'hf;
      dram_wr_n_reg <= 1'b1;
      addr_col_reg <= 1'b0;
      latch_en_reg <= 1'b0;
      xcv_to_cpu_reg <= 1'b0;
      ack_reg <= 1'b0;
      rd_word_reg <= 1'b0;
      reset_cycle_active_reg <= 1'b1;
      ref_ack_reg <= 1'b0;
    end else begin
      ras_n_reg <= ras_next;
      cas_n_reg <= cas_next;
      wb_n_reg <= be_n | {4{wr_next}};
      dram_wr_n_reg <= wr_next;
      addr_col_reg <= col_next;
      latch_en_reg <= le_next;
      xcv_to_cpu_reg <= dir_next;
      ack_reg <= ack_next;
      rd_word_reg <= rdw_next;
      reset_cycle_active_reg <= rip_next;
      ref_ack_reg <= refack_next;
    end
  end

  // A finished access must not restart while the processor still holds its
  // strobe, so requests wait until both strobes have gone high.
  always_ff @(posedge clock) begin
    if (rst) begin
      done_reg <= 1'b0;
      blk_word_reg <= 2'h0;
    end else begin
      done_reg <= ack_next | (done_reg & ~(rd_n & wr_n));
      blk_word_reg <= (st_reg == DBC_IDLE) ? 2'h0 : blk_word_reg + {1'b0, rd_word_reg};
    end
  end

  // --------------------------------------------------------------------------
  // Refresh timer
  // --------------------------------------------------------------------------
  // R8 - R23 - timer steps at bus rate, reloads at top
  // R16 - R25 - pulse sets pending, set beats clear
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_reg <= '0;
      tmr_reg <= `DBC_REF_LOAD;
      ref_pulse_reg <= 1'b0;
      ref_pend_reg <= 1'b0;
    end else begin
      pre_reg <= tick ? '0 : pre_reg + PW'(1);
      ref_pulse_reg <= tick & (tmr_reg == `DBC_REF_TOP);
      ref_pend_reg <= ref_pulse_reg | (ref_pend_reg & ~ref_start);
      if (ref_start || (tick && tmr_reg == `DBC_REF_TOP)) begin
        tmr_reg <= `DBC_REF_LOAD;
      end else if (tick) begin
        tmr_reg <= tmr_reg + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [11:0] row_age_reg;
  always_ff @(posedge clock) begin
    if (rst || ras_n_reg == 4'hf) begin
      row_age_reg <= 12'h000;
    end else begin
      row_age_reg <= row_age_reg + 12'h001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_space_ignore: assert property (st_reg == DBC_IDLE && !ref_pend_reg && !in_space |=> st_reg == DBC_IDLE) // R1 R15
    else $error("access outside DRAM space was started");
  a_bank_pick: assert property (st_reg == DBC_IDLE && !ref_pend_reg && req_rd |=> bank_reg == $past(addr_bank)) // R2
    else $error("bank does not follow address bits");
  a_one_row: assert property (!is_ref |-> $onehot0(~ras_n_reg)) // R4
    else $error("more than one bank row strobe low");
  a_lane_write: assert property (!dram_wr_n_reg |-> wb_n_reg == $past(be_n)) // R6 R7
    else $error("lane enables differ from byte enables");
  a_lane_idle: assert property (dram_wr_n_reg |-> wb_n_reg == 4'hf) // R7
    else $error("lane enable without write");
  a_row_limit: assert property (row_age_reg < 12'(`DBC_TRAS_MAX_CYC)) // R9
    else $error("row strobe held too long");
  a_timer_wrap: assert property (tick && tmr_reg == `DBC_REF_TOP && !ref_start |=> ref_pulse_reg && tmr_reg == `DBC_REF_LOAD) // R23
    else $error("timer did not reload at top");
  a_pend_keep: assert property (ref_pulse_reg |=> ref_pend_reg) // R25 R16
    else $error("refresh request lost");
  a_reset_ref: assert property (st_reg == DBC_RESET && cnt_reg == `DBC_T_REF_END
                                |=> st_reg == DBC_IDLE && ref_ack_reg && !reset_cycle_active_reg) // R13
    else $error("reset refresh did not end in idle");
  a_ref_first: assert property (st_reg == DBC_IDLE && ref_pend_reg |=> st_reg == DBC_REFRESH) // R14
    else $error("refresh not granted first");
  a_prechg_exit: assert property (st_reg == DBC_IDLE_RAS && st_next == DBC_PRECHG |=> ##1 ras_n_reg == 4'hf) // R20
    else $error("row not released before next transaction");
  a_page_row: assert property (st_reg == DBC_WR_PAGE |-> ras_n_reg == ~bank_dec(bank_reg)) // R19
    else $error("page write reopened the row");
  a_col_setup: assert property (!is_ref && cas_n_reg != 4'hf |-> $past(addr_col_reg)) // R24
    else $error("column address not set before CAS");

  c_block_read: cover property (st_reg == DBC_RD_BLK && cnt_reg == `DBC_T_BLK_END);
  c_page_write: cover property (st_reg == DBC_WR_PAGE && ack_next);
  c_ras_refresh: cover property (st_reg == DBC_IDLE_RAS && ref_pend_reg);
  c_single_read: cover property (st_reg == DBC_RD_SGL && ack_next);

endmodule

// >>> test/dbc_cpu_model.sv
// Processor bus model for the DRAM bank controller bench.
// Assumes one clock, active-low strobes and a one-cycle ack pulse.
`timescale 1ns/1ps

module dbc_cpu_model (
  input  wire logic        clock,
  input  wire logic        ack_reg,
  input  wire logic        rd_word_reg,
  input  wire logic [3:0]  ras_n_reg,
  input  wire logic [3:0]  cas_n_reg,
  input  wire logic [3:0]  wb_n_reg,
  input  wire logic        dram_wr_n_reg,
  output logic      [22:0] addr,
  output logic             rd_n,
  output logic             wr_n,
  output logic      [3:0]  be_n,
  output logic             block_req,
  output logic             wr_near
);
  initial begin
    addr      = 23'h400000;
    rd_n      = 1'b1;
    wr_n      = 1'b1;
    be_n      = 4'hf;
    block_req = 1'b0;
    wr_near   = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // One bus transfer, held until ack is sampled high or max_wait cycles pass
  // ---------------------------------------------------------------------------
  task automatic access(input logic [22:0] a, input logic rd, input logic blk, input logic near,
                        input logic [3:0] be, input int max_wait, output int lat,
                        output logic [3:0] ras_m, output logic [3:0] cas_m, output logic [3:0] wb_m,
                        output int words);
    int n;
    lat   = -1;
    words = 0;
    ras_m = 4'h0;
    cas_m = 4'h0;
    wb_m  = 4'h0;
    @(posedge clock);
    #1;
    addr      = a;
    rd_n      = ~rd;
    wr_n      = rd;
    be_n      = be;
    block_req = blk;
    wr_near   = near;
    for (n = 1; n <= max_wait && lat < 0; n++) begin
      @(posedge clock);
      ras_m |= ~ras_n_reg;
      cas_m |= ~cas_n_reg;
      if (dram_wr_n_reg === 1'b0) begin
        wb_m |= ~wb_n_reg;
      end
      if (rd_word_reg === 1'b1) begin
        words++;
      end
      if (ack_reg === 1'b1) begin
        lat = n;
      end
    end
    // Released lines show a changed pattern so stale values cannot pass.
    #1;
    rd_n      = 1'b1;
    wr_n      = 1'b1;
    block_req = 1'b0;
    wr_near   = 1'b0;
    be_n      = ~be;
    addr      = ~a;
  endtask
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the DRAM bank controller.
// Assumes dbc_ctrl at its default refresh divider and a 200 MHz clock.
`timescale 1ns/1ps

`include "dbc_params.svh"

module tb_top;
  logic        clock;
  logic        rst;
  logic [22:0] addr;
  logic        rd_n;
  logic        wr_n;
  logic [3:0]  be_n;
  logic        block_req;
  logic        wr_near;
  logic [3:0]  ras_n_reg;
  logic [3:0]  cas_n_reg;
  logic [3:0]  wb_n_reg;
  logic        dram_wr_n_reg;
  logic        ack_reg;
  logic        rd_word_reg;
  logic        reset_cycle_active_reg;
  logic        ref_ack_reg;
  logic        addr_col_reg;
  logic        latch_en_reg;
  logic        xcv_to_cpu_reg;
  logic [1:0]  blk_word_reg;
  int          le_cnt;
  logic [1:0]  blk_max;
  logic        xcv_seen;
  logic        col_seen;
  int          fails;
  int          num_checks;
  int          cyc;
  int          lat;
  int          words;
  int          low_cnt [4];
  logic [3:0]  rm;
  logic [3:0]  cm;
  logic [3:0]  wm;

  dbc_ctrl u_dut (
    .clock(clock), .rst(rst), .addr(addr), .rd_n(rd_n), .wr_n(wr_n), .be_n(be_n),
    .block_req(block_req), .wr_near(wr_near), .ras_n_reg(ras_n_reg), .cas_n_reg(cas_n_reg),
    .wb_n_reg(wb_n_reg), .dram_wr_n_reg(dram_wr_n_reg), .addr_col_reg(addr_col_reg),
    .latch_en_reg(latch_en_reg), .xcv_to_cpu_reg(xcv_to_cpu_reg), .ack_reg(ack_reg),
    .rd_word_reg(rd_word_reg), .blk_word_reg(blk_word_reg),
    .reset_cycle_active_reg(reset_cycle_active_reg), .ref_ack_reg(ref_ack_reg)
  );

  dbc_cpu_model u_cpu (
    .clock(clock), .ack_reg(ack_reg), .rd_word_reg(rd_word_reg), .ras_n_reg(ras_n_reg),
    .cas_n_reg(cas_n_reg), .wb_n_reg(wb_n_reg), .dram_wr_n_reg(dram_wr_n_reg), .addr(addr),
    .rd_n(rd_n), .wr_n(wr_n), .be_n(be_n), .block_req(block_req), .wr_near(wr_near)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ---------------------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Clears the side monitors of latch, direction, column select and word index.
  task automatic clr_mon();
    le_cnt   = 0;
    blk_max  = 2'h0;
    xcv_seen = 1'b0;
    col_seen = 1'b0;
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Row-low watchdog per bank and run-time ceiling; the 15000-cycle ceiling spans nearly eight 1920-cycle refresh periods.
  always @(posedge clock) begin
    cyc++;
    if (latch_en_reg === 1'b1) le_cnt++;
    if (xcv_to_cpu_reg === 1'b1) xcv_seen = 1'b1;
    if (addr_col_reg === 1'b1) col_seen = 1'b1;
    if (blk_word_reg > blk_max) blk_max = blk_word_reg;
    for (int b = 0; b < 4; b++) begin
      low_cnt[b] = (rst === 1'b0 && ras_n_reg[b] === 1'b0) ? low_cnt[b] + 1 : 0;
      chk(low_cnt[b] <= `DBC_TRAS_MAX_CYC, 1);
    end
    if (cyc > 15000) begin
      fails++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    int n;
    n = 0;
    chk(reset_cycle_active_reg, 1);
    repeat (12) begin
      @(posedge clock);
      if (ref_ack_reg === 1'b1) n++;
    end
    chk(n, 1);
    chk(reset_cycle_active_reg, 0);
    chk(ras_n_reg, 4'hf);
  endtask

  task automatic t_reads();
    for (int b = 0; b < 4; b++) begin
      clr_mon();
      u_cpu.access({1'b0, 2'(b), 20'h00040}, 1, 0, 0, 4'h0, 40, lat, rm, cm, wm, words);
      chk(le_cnt, 1);
      chk(xcv_seen, 1);
      chk(col_seen, 1);
      chk(rm, 4'h1 << b);
      chk(cm, 4'h1 << b);
      chk(words, 1);
      chk(wm, 4'h0);
      if (b == 0) chk(lat, 7);
    end
  endtask

  task automatic t_block();
    clr_mon();
    u_cpu.access(23'h200100, 1, 1, 0, 4'h0, 60, lat, rm, cm, wm, words);
    chk(words, 4);
    chk(le_cnt, 4);
    chk(blk_max, 2'h3);
    chk(rm, 4'h4);
  endtask

  task automatic t_write_page();
    clr_mon();
    u_cpu.access(23'h100200, 0, 0, 0, 4'ha, 40, lat, rm, cm, wm, words);
    chk(wm, 4'h5);
    chk(xcv_seen, 0);
    chk(rm, 4'h2);
    repeat (3) @(posedge clock);
    chk(ras_n_reg, 4'hd);
    chk(cas_n_reg, 4'hf);
    u_cpu.access(23'h100204, 0, 0, 1, 4'h0, 40, lat, rm, cm, wm, words);
    chk(lat, 5);
    chk(wm, 4'hf);
    u_cpu.access(23'h000300, 1, 0, 0, 4'h0, 60, lat, rm, cm, wm, words);
    chk(lat >= 10, 1);
    chk(words, 1);
  endtask

  task automatic t_outside();
    u_cpu.access(23'h400010, 1, 0, 0, 4'h0, 30, lat, rm, cm, wm, words);
    chk(lat, -1);
    chk(rm, 4'h0);
    u_cpu.access(23'h700010, 0, 0, 0, 4'h0, 30, lat, rm, cm, wm, words);
    chk(lat, -1);
  endtask

  task automatic t_refresh();
    int n;
    n = 0;
    while (ref_ack_reg !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    @(posedge clock);
    while (ref_ack_reg !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    chk(n >= 240 * `DBC_TICK_DIV && n <= 240 * `DBC_TICK_DIV + 20, 1);
  endtask

  task automatic t_row_hold();
    int n;
    n = 0;
    u_cpu.access(23'h300040, 0, 0, 0, 4'h3, 40, lat, rm, cm, wm, words);
    chk(wm, 4'hc);
    repeat (4500) begin
      @(posedge clock);
      if (ref_ack_reg === 1'b1) n++;
    end
    chk(n >= 2, 1);
    chk(ras_n_reg, 4'hf);
  endtask

  // A reset in mid-run, with a row held open, must close it and redo the reset refresh.
  task automatic t_reset_mid();
    u_cpu.access(23'h000080, 0, 0, 0, 4'h0, 40, lat, rm, cm, wm, words);
    chk(rm, 4'h1);
    @(posedge clock);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    chk(ras_n_reg, 4'hf);
    t_reset();
  endtask

  initial begin
    fails      = 0;
    num_checks = 0;
    cyc        = 0;
    clr_mon();
    rst        = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset();
    t_reads();
    t_block();
    t_write_page();
    t_outside();
    t_refresh();
    t_row_hold();
    t_reset_mid();
    give_verdict();
  end
endmodule
